//--- rtc_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define RTC_CTRL_OFS      12'h000
`define RTC_PRESCALE_OFS  12'h004
`define RTC_DIVIDER_OFS   12'h008
`define RTC_TIME_OFS      12'h00c
`define RTC_ALARM_OFS     12'h010
`define RTC_CYCLE_N_OFS   12'h014
`define RTC_STATUS_OFS    12'h018
`define RTC_IRQ_EN_OFS    12'h01c
`define RTC_IRQ_CLR_OFS   12'h020
`define RTC_PWR_STAT_OFS  12'h024

// ----------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------
`define CTRL_RUN_BIT      0
`define CTRL_OSCOFF_BIT   1
`define CTRL_KEEP_BIT     2
`define CTRL_WAKE_BIT     3
`define CTRL_RESET        32'h0000_0001

// ----------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------
`define ST_TICK_BIT       0
`define ST_ALARM_BIT      1
`define ST_CYCLE_BIT      2
`define ST_W              3

// ----------------------------------------------------------------------
// widths, resets and timing
// ----------------------------------------------------------------------
`define PRE_DIV           6'h3f
`define DIV_W             20
`define PRESCALE_RESET    20'h0_0000
`define LP_DETECT_EDGES   8'h10
`define LP_DETECT_WIN     16'hffff

`endif

//--- rtc_pkg.sv
// types shared by the real-time clock block
package rtc_pkg;
    typedef enum logic [1:0] {
        SRC_DETECT,
        SRC_LOWPOWER,
        SRC_MAIN
    } clk_src_t;
endpackage

//--- rtc_timebase_alarm.sv
// real-time clock: tick divider, time counter, alarm and apb registers
//
// Operation
// [RULE_01] The time base counts from the main or low-power source and can keep counting in power-down.
// [RULE_02] The clock feeding the tick divider is first divided by a fixed sixty-four.
// [RULE_03] A 20-bit divider reloads from the prescale register each tick, so that register sets the period.
// [RULE_04] A tick request can be raised once per basic tick when enabled.
// [RULE_05] A cyclic request fires after a programmable number n of ticks.
// [RULE_06] A 32-bit time counter can be preset by software and advances on every tick.
// [RULE_07] The time counter is compared with a 32-bit alarm and an alarm request is raised on equality.
// [RULE_08] Prescaler, divider and time counter together form a 58-bit timer readable by software.
// [RULE_09] Tick and alarm requests go to the external interrupt select and wake the chip.
// [RULE_10] Wake from power-down happens only when the wake configuration bit is set.
// [RULE_11] With the oscillator-off bit set, the clock oscillator stops on power-down entry.
// [RULE_12] With the clock disabled, both oscillators are turned off in power-down.
// [RULE_13] After reset the block detects a 32 kHz oscillation and selects it if present.
// [RULE_14] With the low-power source, the main oscillator is off in power-down, time runs as configured.
// [RULE_15] With the main source, the main oscillator stays on in power-down unless the clock is disabled; the code also stops it if oscillator-off is set.
// [RULE_16] All registers are reached over the peripheral bus.
// [RULE_17] Tick and alarm requests are sticky flags until software clears them.
`timescale 1ns/100ps
`include "rtc_defines.svh"

module rtc_timebase_alarm (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        lowpower_osc_in,
    input  wire logic        powerdown,
    output logic             tick_irq,
    output logic             alarm_irq,
    output logic             irq,
    output logic             ext_irq_source_select,
    output logic             wake_req,
    output logic             main_osc_en,
    output logic             lowpower_osc_en,
    output logic             lowpower_osc_out
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [31:0]          clock_unit_control;
    logic [`DIV_W-1:0]    tick_prescale_reload;
    logic [`DIV_W-1:0]    divider;
    logic [5:0]           pre64;
    logic [31:0]          time_count;
    logic [31:0]          alarm_value;
    logic [31:0]          cycle_n;
    logic [31:0]          cycle_count;
    logic [`ST_W-1:0]     status;
    logic [`ST_W-1:0]     irq_enable;
    rtc_pkg::clk_src_t    clk_src;
    logic [7:0]           lp_edges;
    logic [15:0]          lp_window;
    logic                 lp_prev;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire access   = psel && penable && clk_en;
    wire wr       = access && pwrite;
    wire wr_ctrl  = wr && (paddr == `RTC_CTRL_OFS);
    wire wr_pre   = wr && (paddr == `RTC_PRESCALE_OFS);
    wire wr_time  = wr && (paddr == `RTC_TIME_OFS);
    wire wr_alarm = wr && (paddr == `RTC_ALARM_OFS);
    wire wr_cyc   = wr && (paddr == `RTC_CYCLE_N_OFS);
    wire wr_en    = wr && (paddr == `RTC_IRQ_EN_OFS);
    wire wr_clr   = wr && (paddr == `RTC_IRQ_CLR_OFS);
    wire mapped   = (paddr[1:0] == 2'h0) && (paddr <= `RTC_PWR_STAT_OFS);

    // ------------------------------------------------------------------
    // time base
    // ------------------------------------------------------------------
    wire run        = clock_unit_control[`CTRL_RUN_BIT];
    wire osc_off_in_powerdown = clock_unit_control[`CTRL_OSCOFF_BIT];
    wire keep_run   = clock_unit_control[`CTRL_KEEP_BIT];
    wire powerdown_wake_config = clock_unit_control[`CTRL_WAKE_BIT];
    // counting stops in power-down when the oscillator is switched off
    wire pd_stop    = powerdown && (osc_off_in_powerdown ||
                      (clk_src == rtc_pkg::SRC_LOWPOWER && !keep_run));
    wire counting   = run && !pd_stop && clk_en; // [RULE_01]
    wire pre_tc     = counting && (pre64 == `PRE_DIV); // [RULE_02]
    wire tick       = pre_tc && (divider == '0);
    wire next_alarm = tick && (time_count + 32'h1 == alarm_value);
    wire cyc_hit    = tick && (cycle_n != 32'h0) &&
                      (cycle_count + 32'h1 >= cycle_n);
    wire [`ST_W-1:0] events = {cyc_hit, next_alarm, tick};

    // fixed pre-divider by sixty-four
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre64 <= 6'h0;
        end else if (counting) begin
            pre64 <= pre64 + 6'h1; // [RULE_02]
        end
    end

    // divider reloads at every tick so the reload value sets the period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divider <= `PRESCALE_RESET;
        end else if (wr_pre) begin
            divider <= pwdata[`DIV_W-1:0];
        end else if (tick) begin
            divider <= tick_prescale_reload; // [RULE_03]
        end else if (pre_tc) begin
            divider <= divider - 20'h1;
        end
    end

    // time counter: preset by software, else advance on tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            time_count <= 32'h0;
        end else if (wr_time) begin
            time_count <= pwdata; // [RULE_06]
        end else if (tick) begin
            time_count <= time_count + 32'h1; // [RULE_06]
        end
    end

    // cyclic count of n ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle_count <= 32'h0;
        end else if (wr_cyc || cyc_hit) begin
            cycle_count <= 32'h0; // [RULE_05]
        end else if (tick) begin
            cycle_count <= cycle_count + 32'h1;
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_unit_control   <= `CTRL_RESET;
            tick_prescale_reload <= `PRESCALE_RESET;
            alarm_value          <= 32'hffff_ffff;
            cycle_n              <= 32'h0;
            irq_enable           <= '0;
        end else begin
            if (wr_ctrl)  clock_unit_control   <= {28'h0, pwdata[3:0]};
            if (wr_pre)   tick_prescale_reload <= pwdata[`DIV_W-1:0];
            if (wr_alarm) alarm_value          <= pwdata; // [RULE_07]
            if (wr_cyc)   cycle_n              <= pwdata; // [RULE_05]
            if (wr_en)    irq_enable           <= pwdata[`ST_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // sticky request flags, set wins over clear
    // ------------------------------------------------------------------
    wire [`ST_W-1:0] clr_mask = wr_clr ? pwdata[`ST_W-1:0] : '0;
    generate
        for (genvar i = 0; i < `ST_W; i++) begin : g_flag
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    status[i] <= 1'b0;
                end else if (events[i]) begin
                    status[i] <= 1'b1; // [RULE_17]
                end else if (clr_mask[i]) begin
                    status[i] <= 1'b0;
                end
            end
        end
    endgenerate

    wire [`ST_W-1:0] pending = status & irq_enable;
    assign tick_irq  = pending[`ST_TICK_BIT];  // [RULE_04]
    assign alarm_irq = pending[`ST_ALARM_BIT]; // [RULE_07]
    assign irq       = |pending;               // [RULE_05]
    // tick or alarm is routed to the fast external interrupt select
    assign ext_irq_source_select = tick_irq || alarm_irq; // [RULE_09]
    // wake only when the wake bit allows it
    assign wake_req  = powerdown && powerdown_wake_config &&
                       ext_irq_source_select; // [RULE_10]

    // ------------------------------------------------------------------
    // low-power oscillator detection after reset
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_src   <= rtc_pkg::SRC_DETECT;
            lp_edges  <= 8'h0;
            lp_window <= 16'h0;
            lp_prev   <= 1'b0;
        end else if (clk_en) begin
            lp_prev <= lowpower_osc_in;
            case (clk_src)
                rtc_pkg::SRC_DETECT: begin
                    lp_window <= lp_window + 16'h1;
                    if (lowpower_osc_in != lp_prev) begin
                        lp_edges <= lp_edges + 8'h1;
                    end
                    if (lp_edges >= `LP_DETECT_EDGES) begin
                        clk_src <= rtc_pkg::SRC_LOWPOWER; // [RULE_13]
                    end else if (lp_window == `LP_DETECT_WIN) begin
                        clk_src <= rtc_pkg::SRC_MAIN;
                    end
                end
                rtc_pkg::SRC_LOWPOWER: clk_src <= rtc_pkg::SRC_LOWPOWER;
                rtc_pkg::SRC_MAIN:     clk_src <= rtc_pkg::SRC_MAIN;
                default:               clk_src <= rtc_pkg::SRC_DETECT;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // oscillator enables in power-down
    // ------------------------------------------------------------------
    wire lp_sel = (clk_src == rtc_pkg::SRC_LOWPOWER);
    // main oscillator off when low-power drives time, or clock disabled
    assign main_osc_en = !powerdown ||
                         (!lp_sel && run && !osc_off_in_powerdown); // [RULE_14] [RULE_15] [RULE_12]
    // low-power oscillator follows run and oscillator-off settings
    assign lowpower_osc_en = !powerdown ||
                             (lp_sel && run && keep_run &&
                              !osc_off_in_powerdown); // [RULE_11] [RULE_12]
    assign lowpower_osc_out = lowpower_osc_en && !lowpower_osc_in;

    // ------------------------------------------------------------------
    // read mux, registered data; 58-bit timer readable in pieces
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        case (paddr)
            `RTC_CTRL_OFS:     rd_mux = clock_unit_control;
            `RTC_PRESCALE_OFS: rd_mux = {12'h0, tick_prescale_reload};
            `RTC_DIVIDER_OFS:  rd_mux = {6'h0, pre64, divider}; // [RULE_08]
            `RTC_TIME_OFS:     rd_mux = time_count;             // [RULE_08]
            `RTC_ALARM_OFS:    rd_mux = alarm_value;
            `RTC_CYCLE_N_OFS:  rd_mux = cycle_n;
            `RTC_STATUS_OFS:   rd_mux = {29'h0, status};
            `RTC_IRQ_EN_OFS:   rd_mux = {29'h0, irq_enable};
            `RTC_PWR_STAT_OFS: rd_mux = {30'h0, clk_src};
            default:           rd_mux = 32'h0;
        endcase
    end

    // zero-wait slave: data settles in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite && clk_en) begin
            prdata <= rd_mux; // [RULE_16]
        end
    end

    assign pready  = clk_en;
    assign pslverr = psel && penable && !mapped;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // every check runs on pclk and is silent while presetn is low;
    // the counters are free running, so several checks compare a value
    // with its own value one edge earlier rather than with a constant;
    // checks on clk_en matter because a frozen block must not lose
    // or invent a tick, which would skew the time of day for good
    sequence s_tick;
        tick && !wr_time;
    endsequence

    a_time_advance: assert property (@(posedge pclk) disable iff (!presetn)
        s_tick |=> time_count == $past(time_count) + 32'h1) // [RULE_06]
        else $error("time counter did not advance on tick");

    a_div_reload: assert property (@(posedge pclk) disable iff (!presetn)
        tick && !wr_pre |=> divider == $past(tick_prescale_reload)) // [RULE_03]
        else $error("divider not reloaded on tick");

    a_pre_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        tick |-> pre64 == 6'h3f) // [RULE_02]
        else $error("tick outside prescale terminal count");

    a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        status[0] && !clr_mask[0] |=> status[0]) // [RULE_17]
        else $error("tick flag dropped without clear");

    a_alarm_set: assert property (@(posedge pclk) disable iff (!presetn)
        next_alarm |=> status[`ST_ALARM_BIT]) // [RULE_07]
        else $error("alarm flag not set on match");

    a_tick_irq: assert property (@(posedge pclk) disable iff (!presetn)
        tick && irq_enable[0] && !wr_en |=> tick_irq) // [RULE_04]
        else $error("enabled tick did not request");

    a_wake_gate: assert property (@(posedge pclk) disable iff (!presetn)
        wake_req |-> powerdown_wake_config && powerdown) // [RULE_10]
        else $error("wake without configuration");

    a_main_osc: assert property (@(posedge pclk) disable iff (!presetn)
        powerdown && lp_sel |-> !main_osc_en) // [RULE_14]
        else $error("main oscillator on with low-power source");

    // flags: each event leaves its sticky bit set for software

    a_cyc_set: assert property (@(posedge pclk) // [RULE_05]
        disable iff (!presetn) cyc_hit |=> status[`ST_CYCLE_BIT])
        else $error("cycle flag not set after n ticks");

    a_tick_set: assert property (@(posedge pclk) // [RULE_04]
        disable iff (!presetn) tick |=> status[`ST_TICK_BIT])
        else $error("tick flag not set on tick");

    a_alarm_sticky: assert property (@(posedge pclk) // [RULE_17]
        disable iff (!presetn)
        status[`ST_ALARM_BIT] && !clr_mask[`ST_ALARM_BIT] |=>
        status[`ST_ALARM_BIT])
        else $error("alarm flag dropped without clear");

    // counters: they move only on their own strobe

    a_time_hold: assert property (@(posedge pclk) // [RULE_06]
        disable iff (!presetn) !tick && !wr_time |=> $stable(time_count))
        else $error("time counter moved without tick");

    a_pre_step: assert property (@(posedge pclk) // [RULE_02]
        disable iff (!presetn) counting |=> pre64 == $past(pre64) + 6'h1)
        else $error("fixed pre-divider did not step");

    a_div_step: assert property (@(posedge pclk) // [RULE_03]
        disable iff (!presetn) pre_tc && !tick && !wr_pre |=>
        divider == $past(divider) - 20'h1)
        else $error("divider did not count down");

    a_freeze: assert property (@(posedge pclk) // [RULE_01]
        disable iff (!presetn) !clk_en |=>
        $stable(time_count) && $stable(status) && $stable(divider))
        else $error("state moved while clock enable low");

    a_pd_hold: assert property (@(posedge pclk) // [RULE_14]
        disable iff (!presetn) pd_stop && !wr_time |=>
        $stable(time_count))
        else $error("time counted while stopped in power-down");

    // bus: read data only changes at a read setup cycle

    a_prdata_hold: assert property (@(posedge pclk) // [RULE_16]
        disable iff (!presetn)
        !(psel && !penable && !pwrite && clk_en) |=> $stable(prdata))
        else $error("read data changed outside read setup");

    // clock source and oscillator control in power-down

    a_src_lock: assert property (@(posedge pclk) // [RULE_13]
        disable iff (!presetn)
        clk_src != rtc_pkg::SRC_DETECT |=> $stable(clk_src))
        else $error("clock source changed after detection");

    a_main_kept: assert property (@(posedge pclk) // [RULE_15]
        disable iff (!presetn) powerdown && !lp_sel && run &&
        !osc_off_in_powerdown |-> main_osc_en)
        else $error("main oscillator stopped while it drives time");

    a_off_idle: assert property (@(posedge pclk) // [RULE_12]
        disable iff (!presetn) powerdown && !run |->
        !main_osc_en && !lowpower_osc_en)
        else $error("oscillator left on with clock disabled");

    a_osc_off: assert property (@(posedge pclk) // [RULE_11]
        disable iff (!presetn) powerdown && osc_off_in_powerdown |->
        !lowpower_osc_en && !main_osc_en)
        else $error("oscillator on despite oscillator-off bit");

    a_wake_route: assert property (@(posedge pclk) // [RULE_09]
        disable iff (!presetn)
        powerdown && powerdown_wake_config && alarm_irq |-> wake_req)
        else $error("enabled alarm did not wake the chip");

endmodule

//--- rtc_timebase_alarm_tb_top.sv
// self-checking bench for the real-time clock block
`timescale 1ns/100ps
`include "rtc_defines.svh"

module rtc_timebase_alarm_tb_top;
    logic        pclk, presetn, clk_en, psel, penable, pwrite, pready;
    logic        pslverr, powerdown, osc_toggle, lerr;
    logic        lowpower_osc_in = 1'b0;
    logic        tick_irq, alarm_irq, irq, ext_irq_source_select;
    logic        wake_req, main_osc_en, lowpower_osc_en, lowpower_osc_out;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed, m_time, rel, dt;
    int          error_cnt = 0;
    int          checked = 0;
    int          cyc = 0;
    int          per;
    logic [11:0] ra [0:5] = '{`RTC_STATUS_OFS, `RTC_CTRL_OFS,
        `RTC_PRESCALE_OFS, `RTC_ALARM_OFS, `RTC_CYCLE_N_OFS, `RTC_IRQ_EN_OFS};
    logic [31:0] rv [0:5] = '{32'h0, 32'h1, 32'h0, 32'hffff_ffff, 32'h0,
        32'h0};

    rtc_timebase_alarm uut (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lowpower_osc_in(lowpower_osc_in),
        .powerdown(powerdown), .tick_irq(tick_irq),
        .alarm_irq(alarm_irq), .irq(irq),
        .ext_irq_source_select(ext_irq_source_select),
        .wake_req(wake_req), .main_osc_en(main_osc_en),
        .lowpower_osc_en(lowpower_osc_en),
        .lowpower_osc_out(lowpower_osc_out));

    // ----------------------------------------
    // clock, low-power crystal stand-in, hang guard
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // toggling every other cycle is far faster than the detection window
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (osc_toggle && cyc[0])
            lowpower_osc_in <= ~lowpower_osc_in;
        if (cyc == 98000) begin
            error_cnt = error_cnt + 1;
            end_of_test();
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checked = checked + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // pins are looked at mid-cycle, once the edge's updates have landed
    // by reference, so the pin is read at the negedge and not at the call
    task automatic chkb(ref logic got, input logic exp,
                        input string what);
        @(negedge pclk);
        chk(got, exp, what);
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        lerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // two time reads launched exactly k tick periods apart
    task automatic span(input int k);
        logic [31:0] t;
        apb(1'b0, `RTC_TIME_OFS, 32'h0);
        t = rd;
        repeat (k * per - 3) @(posedge pclk);
        apb(1'b0, `RTC_TIME_OFS, 32'h0);
        dt = rd - t;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        presetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        powerdown = 1'b0;
        osc_toggle = 1'b1;
        seed = 32'h0001_6249; // starting value 90697
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // status goes first, before the first tick can set a flag
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ra[i], 32'h0);
            chk(rd, rv[i], "reset value");
            chk(lerr, 1'b0, "mapped read err");
        end
        apb(1'b1, 12'h028, 32'hffff_ffff);
        chk(lerr, 1'b1, "unmapped write err");
        apb(1'b0, 12'h028, 32'h0);
        chk(rd, 32'h0, "unmapped read data");
        apb(1'b0, 12'h006, 32'h0);
        chk(lerr, 1'b1, "unaligned read err");
        chkb(main_osc_en, 1'b1, "main osc awake");
        // random reload; the old reload of zero runs out within 64 cycles
        seed = xs(seed);
        rel = {29'h0, seed[2:0]};
        per = 64 * (int'(rel) + 1);
        apb(1'b1, `RTC_PRESCALE_OFS, rel);
        apb(1'b0, `RTC_DIVIDER_OFS, 32'h0);
        chk(rd[31:26], 6'h0, "divider top");
        chk(rd[19:0] <= rel[19:0], 1'b1, "divider range");
        repeat (64) @(posedge pclk);
        span(3);
        chk(dt, 32'h3, "ticks in span");
        // preset time, alarm three ticks ahead
        seed = xs(seed);
        m_time = seed;
        apb(1'b1, `RTC_TIME_OFS, m_time);
        apb(1'b0, `RTC_TIME_OFS, 32'h0);
        chk(rd - m_time <= 1, 1'b1, "time preset");
        apb(1'b1, `RTC_ALARM_OFS, m_time + 3);
        apb(1'b1, `RTC_IRQ_CLR_OFS, 32'h7);
        apb(1'b1, `RTC_IRQ_EN_OFS, 32'h2);
        chkb(alarm_irq, 1'b0, "alarm early");
        repeat (4 * per) @(posedge pclk);
        chkb(alarm_irq, 1'b1, "alarm raised");
        chkb(irq, 1'b1, "irq on alarm");
        chkb(tick_irq, 1'b0, "tick masked");
        chkb(ext_irq_source_select, 1'b1, "ext select");
        @(posedge pclk);
        powerdown <= 1'b1;
        chkb(wake_req, 1'b0, "wake off");
        apb(1'b1, `RTC_CTRL_OFS, 32'h9);
        chkb(wake_req, 1'b1, "wake on");
        @(posedge pclk);
        powerdown <= 1'b0;
        apb(1'b1, `RTC_CTRL_OFS, 32'h1);
        apb(1'b1, `RTC_IRQ_CLR_OFS, 32'h2);
        chkb(alarm_irq, 1'b0, "alarm cleared");
        // tick flag: align to a fresh tick, next one is per cycles off
        apb(1'b1, `RTC_IRQ_EN_OFS, 32'h1);
        apb(1'b1, `RTC_IRQ_CLR_OFS, 32'h1);
        @(negedge pclk);
        while (tick_irq !== 1'b1) begin
            @(negedge pclk);
        end
        apb(1'b1, `RTC_STATUS_OFS, 32'h0);
        apb(1'b0, `RTC_STATUS_OFS, 32'h0);
        chk(rd[0], 1'b1, "status not writable");
        apb(1'b1, `RTC_IRQ_EN_OFS, 32'h0);
        chkb(irq, 1'b0, "irq masked");
        apb(1'b1, `RTC_IRQ_EN_OFS, 32'h1);
        chkb(tick_irq, 1'b1, "tick unmasked");
        apb(1'b1, `RTC_IRQ_CLR_OFS, 32'h1);
        chkb(tick_irq, 1'b0, "tick cleared");
        // cyclic request after n ticks
        apb(1'b1, `RTC_CYCLE_N_OFS, 32'h3);
        apb(1'b1, `RTC_IRQ_CLR_OFS, 32'h7);
        apb(1'b1, `RTC_IRQ_EN_OFS, 32'h4);
        repeat (4 * per) @(posedge pclk);
        apb(1'b0, `RTC_STATUS_OFS, 32'h0);
        chk(rd[2], 1'b1, "cycle flag");
        chkb(irq, 1'b1, "cycle irq");
        apb(1'b1, `RTC_IRQ_EN_OFS, 32'h0);
        // stopped clock, source and oscillator control in power-down
        apb(1'b1, `RTC_CTRL_OFS, 32'h0);
        span(2);
        chk(dt, 32'h0, "stopped time");
        apb(1'b0, `RTC_PWR_STAT_OFS, 32'h0);
        chk(rd, 32'h1, "lowpower source");
        @(posedge pclk);
        powerdown <= 1'b1;
        chkb(main_osc_en, 1'b0, "main off disabled");
        chkb(lowpower_osc_en, 1'b0, "lp off disabled");
        apb(1'b1, `RTC_CTRL_OFS, 32'h3);
        chkb(lowpower_osc_en, 1'b0, "lp off by bit");
        apb(1'b1, `RTC_CTRL_OFS, 32'h5);
        chkb(lowpower_osc_en, 1'b1, "lp kept");
        chkb(main_osc_en, 1'b0, "main off lp src");
        span(1);
        chk(dt, 32'h1, "time runs in pd");
        @(posedge pclk);
        powerdown <= 1'b0;
        apb(1'b1, `RTC_CTRL_OFS, 32'h1);
        // clk_en low for two periods freezes two ticks of four
        apb(1'b0, `RTC_TIME_OFS, 32'h0);
        m_time = rd;
        @(posedge pclk);
        clk_en <= 1'b0;
        repeat (2 * per - 1) @(posedge pclk);
        chkb(pready, 1'b0, "pready frozen");
        @(posedge pclk);
        clk_en <= 1'b1;
        repeat (2 * per - 4) @(posedge pclk);
        apb(1'b0, `RTC_TIME_OFS, 32'h0);
        chk(rd - m_time, 32'h2, "frozen ticks");
        // no crystal: detection window runs out and main is chosen
        @(posedge pclk);
        presetn <= 1'b0;
        osc_toggle <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (65600) @(posedge pclk);
        apb(1'b0, `RTC_PWR_STAT_OFS, 32'h0);
        chk(rd, 32'h2, "main source");
        @(posedge pclk);
        powerdown <= 1'b1;
        chkb(main_osc_en, 1'b1, "main kept in pd");
        apb(1'b1, `RTC_CTRL_OFS, 32'h0);
        chkb(main_osc_en, 1'b0, "main off disabled");
        end_of_test();
    end
endmodule
